/* File: design/dca_cfg.svh */
// Constants for the central arithmetic datapath
// Assumes inclusion by every design file that needs offsets or values
`ifndef DCA_CFG_SVH
`define DCA_CFG_SVH
// Register offsets (byte addresses)
`define DCA_OFF_CTRL 4'h0
`define DCA_OFF_SUM 4'h4
`define DCA_OFF_PROD 4'h8
`define DCA_OFF_OPND 4'hc
// Control register field positions
`define DCA_CTL_SAT 0
`define DCA_CTL_SXM 1
`define DCA_CTL_PM_LO 2
`define DCA_CTL_PM_HI 3
`define DCA_CTL_ARP_LO 4
`define DCA_CTL_ARP_HI 6
// Carry reset value and saturation limits
`define DCA_CARRY_RST 1'b1
`define DCA_SAT_MAX 32'h7fffffff
`define DCA_SAT_MIN 32'h80000000
// Shift figures
`define DCA_PM_LEFT4 5'd4
`define DCA_PM_RIGHT6 5'd6
`define DCA_HIGH_SHIFT 5'd16
`define DCA_STORE_SHIFT_MAX 3'd7
`endif

/* File: design/dca_pkg.sv */
// Types for the central arithmetic datapath
// Assumes no surroundings beyond the compile order
package dca_pkg;
  typedef enum logic [4:0] {
    DCA_OP_NOP, DCA_OP_LOAD, DCA_OP_ADD, DCA_OP_SUB, DCA_OP_ADD_WITH_CARRY_OP,
    DCA_OP_SUBTRACT_WITH_BORROW_OP, DCA_OP_AND, DCA_OP_OR, DCA_OP_XOR, DCA_OP_ADD_PROD,
    DCA_OP_SUB_PROD, DCA_OP_LOAD_PROD, DCA_OP_MPY_IMM, DCA_OP_LPH,
    DCA_OP_SFL, DCA_OP_SFR, DCA_OP_ROL, DCA_OP_ROR, DCA_OP_SETC,
    DCA_OP_CLRC, DCA_OP_LST1, DCA_OP_LEADING_BIT_ALIGN_OP, DCA_OP_INDEXED_BIT_TEST_OP, DCA_OP_AR_LOAD,
    DCA_OP_ARP_LOAD, DCA_OP_ADD_AR
  } dca_op_t;
  typedef enum logic [1:0] {
    DCA_SRC_MEM, DCA_SRC_SUM, DCA_SRC_PROD, DCA_SRC_IMM
  } dca_src_t;
  typedef enum logic [1:0] {
    DCA_MOD_NONE, DCA_MOD_INC, DCA_MOD_DEC, DCA_MOD_IDX
  } dca_mod_t;
endpackage : dca_pkg

/* File: design/dca_prod_shift.sv */
// Product shifter on the product register output
// Assumes the mode field comes from the control register
`timescale 1ns/1ps
`include "dca_cfg.svh"
module dca_prod_shift import dca_pkg::*; #(
  parameter int W = 32
) (
  // Data
  input wire logic [W-1:0] prod_in,
  input wire logic [1:0] mode_in,
  // Result
  output logic [W-1:0] shifted_out
);
  always_comb begin
    case (mode_in)
      2'b01: shifted_out = prod_in << 1;
      2'b10: shifted_out = prod_in << `DCA_PM_LEFT4;
      2'b11: shifted_out = $signed(prod_in) >>> `DCA_PM_RIGHT6;
      default: shifted_out = prod_in;
    endcase
  end
endmodule : dca_prod_shift

/* File: design/dca_aux_file.sv */
// Auxiliary register file with post-modify address unit
// Assumes the control and core provide select and load data
`timescale 1ns/1ps
`include "dca_cfg.svh"
module dca_aux_file import dca_pkg::*; #(
  parameter int W = 16,
  parameter int N = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Control
  input wire logic [2:0] sel_in,
  input wire logic load_in,
  input wire logic [W-1:0] load_data_in,
  input wire dca_mod_t mod_in,
  // Outputs
  output logic [W-1:0] cur_out,
  output logic [W-1:0] idx_out
);
  logic [W-1:0] ar_reg [N];
  logic [W-1:0] ar_next;
  assign cur_out = ar_reg[sel_in];
  assign idx_out = ar_reg[0];
  always_comb begin
    case (mod_in)
      DCA_MOD_INC: ar_next = cur_out + 1'b1;
      DCA_MOD_DEC: ar_next = cur_out - 1'b1;
      DCA_MOD_IDX: ar_next = cur_out + ar_reg[0];
      default: ar_next = cur_out;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < N; i++) begin
        ar_reg[i] <= '0;
      end
    end else if (load_in) begin
      ar_reg[sel_in] <= load_data_in;
    end else begin
      ar_reg[sel_in] <= ar_next;
    end
  end
endmodule : dca_aux_file

/* File: design/dca_core.sv */
// Central arithmetic unit, sum register, carry and auxiliary registers
// Assumes the sequencer supplies one operation per clock and memory data
//
// Contract
// - multiply by immediate zero clears product
// - unit combines sum with product or input
// - register shift takes operand low four bits
// - indexed bit test uses operand low bits
// - saturation clamps overflow and sets flag
// - no saturation writes raw; logic never overflows
// - overflow, zero status; jump target from sum
// - arithmetic and shifts update carry only
// - carry ops use previous carry value
// - high-half add sets, subtract clears carry
// - reset sets carry; explicit ops write it
// - carry set and clear conditions provided
// - stores shift left zero to seven
// - high store fills from low; low zero-fills
// - right shift arithmetic or logical by mode
// - left shift inserts zero; rotates through carry
// - eight auxiliary registers, three-bit pointer
// - post-modify by one or index register
// - auxiliaries load from sources, feed unit
// - align op shifts sum left to normalize
// - product passes through product shifter
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dca_cfg.svh"
module dca_core import dca_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Operation from the sequencer
  input wire logic op_valid_in,
  input wire dca_op_t op_in,
  input wire logic [15:0] mem_data_in,
  input wire logic [15:0] imm_in,
  input wire logic [4:0] shift_in,
  input wire logic shift_by_opnd_in,
  input wire logic [15:0] mult_opnd_in,
  input wire dca_src_t ar_src_in,
  input wire dca_mod_t ar_mod_in,
  input wire logic [2:0] store_shift_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Status and results
  output logic [31:0] sum_out,
  output logic carry_out,
  output logic carry_clear_out,
  output logic range_exceeded_flag_out,
  output logic sum_zero_out,
  output logic test_bit_out,
  output logic [15:0] jump_target_out,
  output logic [15:0] store_high_out,
  output logic [15:0] store_low_out,
  output logic [15:0] aux_cur_out
);
  // ****************************************
  // Registers and wires
  // ****************************************
  logic [31:0] sum_reg, sum_next;
  logic [31:0] product_register;
  logic [15:0] multiplier_operand_register;
  logic carry_reg, carry_next;
  logic ovf_reg, ovf_next;
  logic saturate_enable, sign_extend_enable;
  logic [1:0] product_shift_field;
  logic [2:0] aux_select_pointer;
  logic [31:0] prod_sh;
  logic [31:0] in_sh;
  logic [4:0] shamt;
  logic [32:0] wide;
  logic [31:0] opnd_b;
  logic ov_raw;
  logic arith_op;
  logic [15:0] aux_cur, aux_load;
  logic aux_load_en;
  logic [15:0] in_ext;
  logic busy_reg;
  logic ctrl_wr;
  logic sum_wr;
  logic [31:0] sum_new;
  // ****************************************
  // Product shifter and input shifter
  // ****************************************
  dca_prod_shift #(.W(32)) u_prod_shift (
    .prod_in(product_register),
    .mode_in(product_shift_field),
    .shifted_out(prod_sh)
  );
  assign shamt = shift_by_opnd_in ?
    {1'b0, multiplier_operand_register[3:0]} : shift_in;
  assign in_ext = (op_in == DCA_OP_ADD_AR) ? aux_cur : mem_data_in;
  assign in_sh = (sign_extend_enable ? {{16{in_ext[15]}}, in_ext}
    : {16'h0000, in_ext}) << shamt;
  // ****************************************
  // Main arithmetic unit
  // ****************************************
  always_comb begin
    opnd_b = in_sh;
    if (op_in == DCA_OP_ADD_PROD || op_in == DCA_OP_SUB_PROD ||
        op_in == DCA_OP_LOAD_PROD) begin
      opnd_b = prod_sh;
    end
  end
  always_comb begin
    wide = {1'b0, sum_reg};
    arith_op = 1'b0;
    case (op_in)
      DCA_OP_ADD, DCA_OP_ADD_PROD, DCA_OP_ADD_AR: begin
        wide = {1'b0, sum_reg} + {1'b0, opnd_b};
        arith_op = 1'b1;
      end
      DCA_OP_ADD_WITH_CARRY_OP: begin
        wide = {1'b0, sum_reg} + {1'b0, opnd_b} + {32'h0, carry_reg};
        arith_op = 1'b1;
      end
      DCA_OP_SUB, DCA_OP_SUB_PROD: begin
        wide = {1'b0, sum_reg} + {1'b0, ~opnd_b} + 33'h1;
        arith_op = 1'b1;
      end
      DCA_OP_SUBTRACT_WITH_BORROW_OP: begin
        wide = {1'b0, sum_reg} + {1'b0, ~opnd_b} + {32'h0, carry_reg};
        arith_op = 1'b1;
      end
      default: begin
        wide = {1'b0, sum_reg};
        arith_op = 1'b0;
      end
    endcase
  end
  // Signed overflow only from arithmetic ops
  always_comb begin
    ov_raw = 1'b0;
    if (arith_op) begin
      if (op_in == DCA_OP_SUB || op_in == DCA_OP_SUB_PROD ||
          op_in == DCA_OP_SUBTRACT_WITH_BORROW_OP) begin
        ov_raw = (sum_reg[31] != opnd_b[31]) && (wide[31] != sum_reg[31]);
      end else begin
        ov_raw = (sum_reg[31] == opnd_b[31]) && (wide[31] != sum_reg[31]);
      end
    end
  end
  // ****************************************
  // Next sum and carry
  // ****************************************
  always_comb begin
    sum_next = sum_reg;
    carry_next = carry_reg;
    ovf_next = ovf_reg;
    if (op_valid_in) begin
      case (op_in)
        DCA_OP_LOAD: sum_next = in_sh;
        DCA_OP_LOAD_PROD: sum_next = prod_sh;
        DCA_OP_AND: sum_next = sum_reg & in_sh;
        DCA_OP_OR: sum_next = sum_reg | in_sh;
        DCA_OP_XOR: sum_next = sum_reg ^ in_sh;
        DCA_OP_ADD, DCA_OP_ADD_WITH_CARRY_OP, DCA_OP_SUB, DCA_OP_SUBTRACT_WITH_BORROW_OP,
        DCA_OP_ADD_PROD, DCA_OP_SUB_PROD, DCA_OP_ADD_AR: begin
          sum_next = wide[31:0];
          if (ov_raw) begin
            ovf_next = 1'b1;
            if (saturate_enable) begin
              sum_next = sum_reg[31] ? `DCA_SAT_MIN : `DCA_SAT_MAX;
            end
          end
          if (op_in == DCA_OP_ADD && !shift_by_opnd_in &&
              shift_in == `DCA_HIGH_SHIFT) begin
            if (wide[32]) carry_next = 1'b1;
          end else if (op_in == DCA_OP_SUB && !shift_by_opnd_in &&
              shift_in == `DCA_HIGH_SHIFT) begin
            if (!wide[32]) carry_next = 1'b0;
          end else begin
            carry_next = wide[32];
          end
        end
        DCA_OP_SFL: begin
          sum_next = {sum_reg[30:0], 1'b0};
          carry_next = sum_reg[31];
        end
        DCA_OP_SFR: begin
          sum_next = {sign_extend_enable & sum_reg[31], sum_reg[31:1]};
          carry_next = sum_reg[0];
        end
        DCA_OP_ROL: begin
          sum_next = {sum_reg[30:0], carry_reg};
          carry_next = sum_reg[31];
        end
        DCA_OP_ROR: begin
          sum_next = {carry_reg, sum_reg[31:1]};
          carry_next = sum_reg[0];
        end
        DCA_OP_LEADING_BIT_ALIGN_OP: begin
          if (sum_reg[31] == sum_reg[30]) begin
            sum_next = {sum_reg[30:0], 1'b0};
          end
        end
        DCA_OP_SETC: carry_next = 1'b1;
        DCA_OP_CLRC: carry_next = 1'b0;
        DCA_OP_LST1: carry_next = mem_data_in[9];
        default: sum_next = sum_reg;
      endcase
    end
  end
  // ****************************************
  // State registers
  // ****************************************
  assign sum_wr = avs_write && !busy_reg && avs_address == `DCA_OFF_SUM;
  assign sum_new = sum_wr ? avs_writedata : sum_next;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sum_reg <= '0;
      carry_reg <= `DCA_CARRY_RST;
      ovf_reg <= 1'b0;
    end else begin
      sum_reg <= sum_new;
      carry_reg <= carry_next;
      ovf_reg <= ovf_next;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      product_register <= '0;
    end else if (op_valid_in && op_in == DCA_OP_MPY_IMM) begin
      product_register <= $signed(multiplier_operand_register) *
        $signed(imm_in);
    end else if (op_valid_in && op_in == DCA_OP_LPH) begin
      product_register <= {mem_data_in, product_register[15:0]};
    end
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      multiplier_operand_register <= '0;
    end else begin
      multiplier_operand_register <= mult_opnd_in;
    end
  end
  // ****************************************
  // Auxiliary registers
  // ****************************************
  always_comb begin
    case (ar_src_in)
      DCA_SRC_SUM: aux_load = sum_reg[15:0];
      DCA_SRC_PROD: aux_load = prod_sh[15:0];
      DCA_SRC_IMM: aux_load = imm_in;
      default: aux_load = mem_data_in;
    endcase
  end
  assign aux_load_en = op_valid_in && op_in == DCA_OP_AR_LOAD;
  dca_aux_file #(.W(16), .N(8)) u_aux (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .sel_in(aux_select_pointer),
    .load_in(aux_load_en),
    .load_data_in(aux_load),
    .mod_in(op_valid_in ? ar_mod_in : DCA_MOD_NONE),
    .cur_out(aux_cur),
    .idx_out()
  );
  // ****************************************
  // Control register and bus slave
  // ****************************************
  assign ctrl_wr = avs_write && !busy_reg && avs_address == `DCA_OFF_CTRL;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      saturate_enable <= 1'b0;
      sign_extend_enable <= 1'b1;
      product_shift_field <= 2'b00;
      aux_select_pointer <= 3'h0;
    end else if (ctrl_wr) begin
      saturate_enable <= avs_writedata[`DCA_CTL_SAT];
      sign_extend_enable <= avs_writedata[`DCA_CTL_SXM];
      product_shift_field <= avs_writedata[`DCA_CTL_PM_HI:`DCA_CTL_PM_LO];
      aux_select_pointer <= avs_writedata[`DCA_CTL_ARP_HI:`DCA_CTL_ARP_LO];
    end else if (op_valid_in && op_in == DCA_OP_ARP_LOAD) begin
      aux_select_pointer <= aux_load[2:0];
    end
  end
  // One wait cycle, then the access completes
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      busy_reg <= 1'b1;
      avs_waitrequest <= 1'b1;
    end else begin
      busy_reg <= !(avs_read || avs_write) || !busy_reg;
      avs_waitrequest <= !((avs_read || avs_write) && busy_reg);
    end
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      avs_readdata <= '0;
    end else if (avs_read && busy_reg) begin
      case (avs_address)
        `DCA_OFF_CTRL: avs_readdata <= {25'h0, aux_select_pointer,
          product_shift_field, sign_extend_enable, saturate_enable};
        `DCA_OFF_SUM: avs_readdata <= sum_reg;
        `DCA_OFF_PROD: avs_readdata <= product_register;
        `DCA_OFF_OPND: avs_readdata <= {16'h0, multiplier_operand_register};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end
  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sum_out <= '0;
      carry_out <= 1'b0;
      carry_clear_out <= 1'b0;
      range_exceeded_flag_out <= 1'b0;
      sum_zero_out <= 1'b0;
      test_bit_out <= 1'b0;
      jump_target_out <= '0;
      store_high_out <= '0;
      store_low_out <= '0;
      aux_cur_out <= '0;
    end else begin
      sum_out <= sum_new;
      carry_out <= carry_next;
      carry_clear_out <= !carry_next;
      range_exceeded_flag_out <= ovf_next;
      sum_zero_out <= (sum_new == 32'h0);
      jump_target_out <= sum_new[15:0];
      if (op_valid_in && op_in == DCA_OP_INDEXED_BIT_TEST_OP) begin
        test_bit_out <= mem_data_in[~multiplier_operand_register[3:0]];
      end
      store_high_out <= 16'((sum_reg << store_shift_in) >> 16);
      store_low_out <= 16'(sum_reg[15:0] << store_shift_in);
      aux_cur_out <= aux_cur;
    end
  end
endmodule : dca_core

/* File: tb/dca_monitor.sv */
// Checker for the central arithmetic datapath
// Assumes it is bound to dca_core and sees only its ports
`timescale 1ns/1ps
module dca_monitor import dca_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Observed
  input wire logic op_valid_in,
  input wire dca_op_t op_in,
  input wire logic [15:0] mem_data_in,
  input wire logic [2:0] store_shift_in,
  input wire logic avs_write,
  input wire logic [31:0] sum_out,
  input wire logic carry_out,
  input wire logic carry_clear_out,
  input wire logic range_exceeded_flag_out,
  input wire logic sum_zero_out,
  input wire logic [15:0] store_low_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic go = op_valid_in && !avs_write;
  a_setc_carry: assert property (go && op_in == DCA_OP_SETC
    |=> carry_out) else $error("carry not set");
  a_clrc_carry: assert property (go && op_in == DCA_OP_CLRC
    |=> !carry_out && carry_clear_out) else $error("carry not clear");
  a_load_carry: assert property (go && op_in inside {DCA_OP_LOAD,
    DCA_OP_AND, DCA_OP_OR, DCA_OP_XOR} |=> $stable(carry_out))
    else $error("carry moved");
  a_zero_flag: assert property (go && op_in == DCA_OP_LOAD &&
    mem_data_in == 16'h0 |=> sum_zero_out) else $error("zero flag");
  a_flag_sticky: assert property (range_exceeded_flag_out
    |=> range_exceeded_flag_out) else $error("flag dropped");
  a_indexed_bit_test_op_sum: assert property (go && op_in == DCA_OP_INDEXED_BIT_TEST_OP
    |=> $stable(sum_out)) else $error("sum changed");
  a_shift_left: assert property (go && op_in == DCA_OP_SFL |=>
    sum_out == ($past(sum_out) << 1) && carry_out == $past(sum_out) >> 31)
    else $error("left shift");
  a_store_low: assert property ((!op_valid_in && !avs_write &&
    $stable(store_shift_in))[*2] |-> store_low_out ==
    16'(sum_out[15:0] << store_shift_in)) else $error("low store");
  c_sat: cover property (range_exceeded_flag_out);
  c_sfl: cover property (go && op_in == DCA_OP_SFL);
  c_indexed_bit_test_op: cover property (go && op_in == DCA_OP_INDEXED_BIT_TEST_OP);
endmodule : dca_monitor
bind dca_core dca_monitor i_mon (.clk_in(clk_in), .nrst_in(nrst_in),
  .op_valid_in(op_valid_in), .op_in(op_in), .mem_data_in(mem_data_in),
  .store_shift_in(store_shift_in), .avs_write(avs_write),
  .sum_out(sum_out), .carry_out(carry_out),
  .carry_clear_out(carry_clear_out), .sum_zero_out(sum_zero_out),
  .range_exceeded_flag_out(range_exceeded_flag_out),
  .store_low_out(store_low_out));

/* File: tb/dca_seq_model.sv */
// Sequencer and memory bus model feeding operations to the core
// Assumes one bench process calls its tasks
`timescale 1ns/1ps
module dca_seq_model import dca_pkg::*; (
  // Clock
  input wire logic clk_in,
  // Operation
  output logic op_valid_out,
  output dca_op_t op_out,
  output logic [15:0] mem_out,
  output logic [15:0] imm_out,
  output logic [4:0] shift_out,
  output logic by_opnd_out,
  output logic [15:0] opnd_out,
  output dca_mod_t mod_out,
  output logic [2:0] store_shift_out
);
  initial begin
    op_valid_out = 1'b0;
    op_out = DCA_OP_NOP;
    {mem_out, imm_out, shift_out, by_opnd_out, opnd_out} = '0;
    mod_out = DCA_MOD_NONE;
    store_shift_out = 3'h0;
  end
  task automatic set_opnd(input logic [15:0] v, input logic [2:0] ss);
    @(posedge clk_in);
    opnd_out <= v;
    store_shift_out <= ss;
  endtask : set_opnd
  task automatic issue(input dca_op_t op, input logic [15:0] d = 16'h0,
      input logic [15:0] im = 16'h0, input logic [4:0] s = 5'h0,
      input logic b = 1'b0, input dca_mod_t md = DCA_MOD_NONE);
    @(posedge clk_in);
    op_valid_out <= 1'b1;
    op_out <= op;
    mem_out <= d;
    imm_out <= im;
    shift_out <= s;
    by_opnd_out <= b;
    mod_out <= md;
    @(posedge clk_in);
    op_valid_out <= 1'b0;
    mod_out <= DCA_MOD_NONE;
  endtask : issue
  task automatic restore(input logic [15:0] hi, lo);
    set_opnd(lo, store_shift_out);
    issue(DCA_OP_MPY_IMM, 16'h0, 16'h1);
    issue(DCA_OP_LPH, hi);
  endtask : restore
endmodule : dca_seq_model

/* File: tb/dca_core_tb_top.sv */
// Self-checking bench for the central arithmetic datapath
// Assumes the model drives operations and this bench the register bus
`timescale 1ns/1ps
`include "dca_cfg.svh"
module dca_core_tb_top import dca_pkg::*;;
  logic clk_in, nrst_in, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, sum_out;
  logic op_valid, by_opnd, carry_out, carry_clear_out, flag, zero, tbit;
  dca_op_t op;
  dca_mod_t md;
  dca_src_t asrc;
  logic [15:0] mem, imm, opnd, jump, st_hi, st_lo, aux;
  logic [4:0] sh;
  logic [2:0] ss;
  int n_mismatch = 0;
  int cmp_count = 0;
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  dca_seq_model m (.clk_in(clk_in), .op_valid_out(op_valid), .op_out(op),
    .mem_out(mem), .imm_out(imm), .shift_out(sh), .by_opnd_out(by_opnd),
    .opnd_out(opnd), .mod_out(md), .store_shift_out(ss));
  dca_core i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .op_valid_in(op_valid), .op_in(op), .mem_data_in(mem), .imm_in(imm),
    .shift_in(sh), .shift_by_opnd_in(by_opnd), .mult_opnd_in(opnd),
    .ar_src_in(asrc), .ar_mod_in(md), .store_shift_in(ss),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sum_out(sum_out), .carry_out(carry_out),
    .carry_clear_out(carry_clear_out), .range_exceeded_flag_out(flag),
    .sum_zero_out(zero), .test_bit_out(tbit), .jump_target_out(jump),
    .store_high_out(st_hi), .store_low_out(st_lo), .aux_cur_out(aux));
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_in);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_in);
      if (!avs_waitrequest) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      final_report();
    end
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rd
  task automatic x(input dca_op_t o, input logic [15:0] d = 16'h0,
      input logic [4:0] s = 5'h0, input logic b = 1'b0);
    m.issue(o, d, 16'h0, s, b);
    @(negedge clk_in);
  endtask : x
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    x(DCA_OP_NOP);
    chk("reset carry", 32'h1, carry_out);
    chk("reset flag", 32'h0, flag);
    rd(`DCA_OFF_CTRL, 32'h2, "ctrl");
    rd(4'h2, 32'h0, "unmapped");
  endtask : t_reset
  task automatic t_sat;
    wr(`DCA_OFF_SUM, 32'h7fffffff);
    x(DCA_OP_ADD, 16'h1);
    chk("raw sum", 32'h80000000, sum_out);
    wr(`DCA_OFF_CTRL, 32'h3);
    wr(`DCA_OFF_SUM, 32'h7fffffff);
    x(DCA_OP_ADD, 16'h1);
    chk("pos sat", `DCA_SAT_MAX, sum_out);
    chk("flag", 32'h1, flag);
    wr(`DCA_OFF_SUM, 32'h80000000);
    x(DCA_OP_SUB, 16'h1);
    chk("neg sat", `DCA_SAT_MIN, sum_out);
    wr(`DCA_OFF_CTRL, 32'h2);
  endtask : t_sat
  task automatic t_carry;
    wr(`DCA_OFF_SUM, 32'hffffffff);
    x(DCA_OP_SETC);
    x(DCA_OP_ADD_WITH_CARRY_OP);
    chk("add_with_carry_op", 32'h0, sum_out);
    chk("add_with_carry_op c", 32'h1, carry_out);
    x(DCA_OP_CLRC);
    x(DCA_OP_SUBTRACT_WITH_BORROW_OP);
    chk("subtract_with_borrow_op", 32'hffffffff, sum_out);
    chk("subtract_with_borrow_op c", 32'h0, carry_out);
    wr(`DCA_OFF_SUM, 32'hffff0000);
    x(DCA_OP_ADD, 16'h1, 5'd16);
    chk("add hi c", 32'h1, carry_out);
    x(DCA_OP_CLRC);
    wr(`DCA_OFF_SUM, 32'h00010000);
    x(DCA_OP_SUB, 16'h1, 5'd16);
    chk("sub hi c", 32'h0, carry_out);
    x(DCA_OP_LOAD);
    chk("zero", 32'h1, zero);
    chk("load c", 32'h0, carry_out);
  endtask : t_carry
  task automatic t_logic;
    wr(`DCA_OFF_SUM, 32'h0000ffff);
    x(DCA_OP_AND, 16'h00f0);
    chk("and", 32'hf0, sum_out);
    x(DCA_OP_OR, 16'h0f00);
    chk("or", 32'hff0, sum_out);
    x(DCA_OP_XOR, 16'h0ff0);
    chk("xor", 32'h0, sum_out);
    chk("logic c", 32'h0, carry_out);
    x(DCA_OP_LST1, 16'h0200);
    chk("lst1 c", 32'h1, carry_out);
    wr(`DCA_OFF_SUM, 32'h20000000);
    x(DCA_OP_LEADING_BIT_ALIGN_OP);
    chk("leading_bit_align_op", 32'h40000000, sum_out);
    x(DCA_OP_LEADING_BIT_ALIGN_OP);
    chk("leading_bit_align_op held", 32'h40000000, sum_out);
  endtask : t_logic
  task automatic t_shift;
    wr(`DCA_OFF_SUM, 32'h80000001);
    x(DCA_OP_SFR);
    chk("sfr a", 32'hc0000000, sum_out);
    wr(`DCA_OFF_CTRL, 32'h0);
    wr(`DCA_OFF_SUM, 32'h80000001);
    x(DCA_OP_SFR);
    chk("sfr l", 32'h40000000, sum_out);
    wr(`DCA_OFF_SUM, 32'h80000001);
    x(DCA_OP_SFL);
    chk("sfl c", 32'h1, carry_out);
    x(DCA_OP_ROR);
    chk("ror", 32'h80000001, sum_out);
    x(DCA_OP_ROL);
    chk("rol", 32'h2, sum_out);
    chk("rol c", 32'h1, carry_out);
    wr(`DCA_OFF_CTRL, 32'h2);
  endtask : t_shift
  task automatic t_store;
    wr(`DCA_OFF_SUM, 32'h12345678);
    m.set_opnd(16'h0, 3'd4);
    repeat (3) @(negedge clk_in);
    chk("hi4", 32'h2345, st_hi);
    chk("lo4", 32'h6780, st_lo);
    chk("jump", 32'h5678, jump);
    m.set_opnd(16'h0, `DCA_STORE_SHIFT_MAX);
    repeat (3) @(negedge clk_in);
    chk("hi7", 32'h1a2b, st_hi);
    chk("lo7", 32'h3c00, st_lo);
    chk("kept", 32'h12345678, sum_out);
  endtask : t_store
  task automatic t_prod;
    m.restore(16'h0012, 16'h5678);
    rd(`DCA_OFF_PROD, 32'h00125678, "restore");
    x(DCA_OP_LOAD_PROD);
    chk("pm0", 32'h00125678, sum_out);
    wr(`DCA_OFF_CTRL, 32'ha);
    x(DCA_OP_LOAD_PROD);
    chk("pm left4", 32'h01256780, sum_out);
    wr(`DCA_OFF_CTRL, 32'he);
    x(DCA_OP_LOAD_PROD);
    chk("pm right6", 32'h00004959, sum_out);
    wr(`DCA_OFF_CTRL, 32'h2);
    x(DCA_OP_ADD_PROD);
    chk("add prod", 32'h00129fd1, sum_out);
    x(DCA_OP_SUB_PROD);
    chk("sub prod", 32'h00004959, sum_out);
    chk("sub prod c", 32'h1, carry_out);
    m.issue(DCA_OP_MPY_IMM);
    rd(`DCA_OFF_PROD, 32'h0, "mpy zero");
  endtask : t_prod
  task automatic t_opnd;
    m.set_opnd(16'h4, 3'd0);
    x(DCA_OP_LOAD, 16'h0012, 5'd0, 1'b1);
    chk("opnd shift", 32'h120, sum_out);
    m.set_opnd(16'h3, 3'd0);
    x(DCA_OP_INDEXED_BIT_TEST_OP, 16'h1000);
    chk("bit", 32'h1, tbit);
    chk("indexed_bit_test_op sum", 32'h120, sum_out);
  endtask : t_opnd
  task automatic t_aux;
    @(posedge clk_in);
    asrc <= DCA_SRC_MEM;
    m.issue(DCA_OP_AR_LOAD, 16'h0055);
    repeat (2) @(negedge clk_in);
    chk("aux mem", 32'h55, aux);
    @(posedge clk_in);
    asrc <= DCA_SRC_IMM;
    m.issue(DCA_OP_AR_LOAD, 16'h0, 16'h0100);
    repeat (2) @(negedge clk_in);
    chk("aux load", 32'h100, aux);
    m.issue(DCA_OP_NOP, 16'h0, 16'h0, 5'h0, 1'b0, DCA_MOD_INC);
    repeat (2) @(negedge clk_in);
    chk("aux inc", 32'h101, aux);
    m.issue(DCA_OP_NOP, 16'h0, 16'h0, 5'h0, 1'b0, DCA_MOD_DEC);
    repeat (2) @(negedge clk_in);
    chk("aux dec", 32'h100, aux);
    m.issue(DCA_OP_NOP, 16'h0, 16'h0, 5'h0, 1'b0, DCA_MOD_IDX);
    repeat (2) @(negedge clk_in);
    chk("aux idx", 32'h200, aux);
    wr(`DCA_OFF_SUM, 32'h0);
    x(DCA_OP_ADD_AR);
    chk("add aux", 32'h200, sum_out);
    m.issue(DCA_OP_ARP_LOAD, 16'h0, 16'h0001);
    rd(`DCA_OFF_CTRL, 32'h12, "pointer");
  endtask : t_aux
  initial begin
    nrst_in = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    asrc = DCA_SRC_IMM;
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_sat();
    t_carry();
    t_logic();
    t_shift();
    t_store();
    t_prod();
    t_opnd();
    t_aux();
    final_report();
  end
endmodule : dca_core_tb_top
